//--- adc_seq_pkg.sv
// shared constants for the converter sequencer
package adc_seq_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL_MAIN   = 8'h14;
   localparam logic [7:0] ADDR_CONFIG_PINS = 8'h15;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h16;
   localparam logic [7:0] ADDR_RESULT_LOW  = 8'h17;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;

   // adc_control_main fields
   localparam int CHAN_LSB  = 4;
   localparam int CHAN_MSB  = 7;
   localparam int GO_BIT    = 2;
   localparam int POWER_BIT = 0;

   // adc_config_pins fields
   localparam int CLKSEL_LSB  = 6;
   localparam int CLKSEL_MSB  = 7;
   localparam int JUSTIFY_BIT = 5;
   localparam int PCFG_LSB    = 1;
   localparam int PCFG_MSB    = 3;
   localparam int REFSEL_BIT  = 0;

   // irq status fields
   localparam int DONE_BIT  = 0;
   localparam int IRQEN_BIT = 1;

   // implemented-bit masks and reset values
   localparam logic [7:0] CTRL_MASK   = 8'hF1;
   localparam logic [7:0] CONFIG_MASK = 8'hEF;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;

   // conversion clock select codes
   localparam logic [1:0] CLK_DIV8  = 2'h0;
   localparam logic [1:0] CLK_DIV32 = 2'h1;
   localparam logic [1:0] CLK_DIV64 = 2'h2;
   localparam logic [1:0] CLK_RC    = 2'h3;

   // divider terminal counts, in device clock periods
   localparam logic [5:0] DIV8_LAST  = 6'h07;
   localparam logic [5:0] DIV32_LAST = 6'h1F;
   localparam logic [5:0] DIV64_LAST = 6'h3F;

   // sequence lengths in bit_conversion_period units
   localparam logic [3:0] CONV_TADS    = 4'hC;
   localparam logic [3:0] HOLDOFF_TADS = 4'h2;
   localparam logic [3:0] RESULT_BITS  = 4'hA;

   // analog-input mask per pin_config_select code, bit n is channel n
   localparam logic [15:0] PIN_MAP [8] = '{
      16'hFFFF, 16'h7F7F, 16'h3F3F, 16'h1F1F,
      16'h0F0F, 16'h0707, 16'h0303, 16'h0000};
   localparam logic [15:0] REF_PIN_MASK = 16'h0003;

   typedef enum logic [3:0] {
      ST_OFF  = 4'h1,
      ST_ACQ  = 4'h2,
      ST_CONV = 4'h4,
      ST_WAIT = 4'h8
   } seq_state_t;

endpackage

//--- adc_tad_clock.sv
// conversion period tick generator
`timescale 1ns/1ps
module adc_tad_clock (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   // control
   input  wire logic       i_enable,
   input  wire logic [1:0] i_clk_sel,
   input  wire logic       i_sleep,
   input  wire logic       i_rc_tick,
   // tick out
   output logic            o_tick
);

   logic [5:0] div_reg;
   logic [5:0] div_next;
   logic       tick_next;
   wire        rc_mode;
   wire        run;
   wire  [5:0] div_last;
   wire        wrap;

   // the device oscillator stops in sleep, only the rc source keeps going
   assign rc_mode  = (i_clk_sel == adc_seq_pkg::CLK_RC);
   assign run      = i_enable && (rc_mode || !i_sleep);
   assign div_last = (i_clk_sel == adc_seq_pkg::CLK_DIV8)  ?
                        adc_seq_pkg::DIV8_LAST :
                     (i_clk_sel == adc_seq_pkg::CLK_DIV32) ?
                        adc_seq_pkg::DIV32_LAST : adc_seq_pkg::DIV64_LAST;
   assign wrap     = (div_reg >= div_last);
   assign div_next = (!run || rc_mode || wrap) ? 6'h00 : div_reg + 6'h01;
   assign tick_next = run && (rc_mode ? i_rc_tick : wrap);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_reg <= 6'h00;
         o_tick  <= 1'b0;
      end else begin
         div_reg <= div_next;
         o_tick  <= tick_next;
      end
   end

endmodule

//--- adc_sequencer_control.sv
// converter sequencer: registers, state machine and approximation register
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module adc_sequencer_control (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // system
   input  wire logic        i_sleep,
   input  wire logic        i_rc_tick,
   input  wire logic        i_global_irq_disable,
   // analog front end
   input  wire logic        i_comparator,
   output logic      [3:0]  o_channel,
   output logic             o_sample_connect,
   output logic      [9:0]  o_dac_code,
   output logic             o_power_on,
   output logic             o_vref_ext,
   output logic      [15:0] o_analog_mask,
   // completion
   output logic             o_done_flag,
   output logic             o_irq_request
);

   adc_seq_pkg::seq_state_t state_reg;
   adc_seq_pkg::seq_state_t state_next;

   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] config_reg;
   logic [7:0] config_next;
   logic       go_reg;
   logic       go_next;
   logic       done_reg;
   logic       done_next;
   logic       irq_en_reg;
   logic       irq_en_next;
   logic [3:0] tad_cnt_reg;
   logic [3:0] tad_cnt_next;
   logic [9:0] sar_reg;
   logic [9:0] sar_next;
   logic [9:0] result_reg;
   logic [9:0] result_next;
   logic [7:0] rd_mux;

   wire        tad_tick;
   wire        wr_ctrl;
   wire        wr_config;
   wire        wr_stat;
   wire        power_on;
   wire        in_conv;
   wire        in_wait;
   wire        in_acq;
   wire        abort;
   wire        complete;
   wire        holdoff_done;
   wire        start;
   wire        sar_phase;
   wire  [3:0] bit_idx;
   wire  [9:0] trial_bit;
   wire  [9:0] dac_next;
   wire  [1:0] clk_sel;
   wire        justify_right;
   wire  [2:0] pcfg;
   wire  [15:0] mask_next;
   wire  [7:0] res_high;
   wire  [7:0] res_low;

   // address decode
   assign wr_ctrl   = i_wr && (i_addr == adc_seq_pkg::ADDR_CTRL_MAIN);
   assign wr_config = i_wr && (i_addr == adc_seq_pkg::ADDR_CONFIG_PINS);
   assign wr_stat   = i_wr && (i_addr == adc_seq_pkg::ADDR_IRQ_STATUS);

   assign power_on      = ctrl_reg[adc_seq_pkg::POWER_BIT];
   assign clk_sel       = config_reg[adc_seq_pkg::CLKSEL_MSB:
                                     adc_seq_pkg::CLKSEL_LSB];
   assign justify_right = config_reg[adc_seq_pkg::JUSTIFY_BIT];
   assign pcfg          = config_reg[adc_seq_pkg::PCFG_MSB:
                                     adc_seq_pkg::PCFG_LSB];

   assign in_conv = (state_reg == adc_seq_pkg::ST_CONV);
   assign in_wait = (state_reg == adc_seq_pkg::ST_WAIT);
   assign in_acq  = (state_reg == adc_seq_pkg::ST_ACQ);

   // clearing go mid-conversion abandons it
   assign abort    = in_conv && wr_ctrl && !i_wdata[adc_seq_pkg::GO_BIT];
   assign complete = in_conv && !abort && tad_tick &&
                     (tad_cnt_reg == adc_seq_pkg::CONV_TADS - 4'h1);
   assign holdoff_done = in_wait && tad_tick &&
                     (tad_cnt_reg == adc_seq_pkg::HOLDOFF_TADS - 4'h1);
   assign start    = in_acq && go_reg && power_on;

   // periods 2..11 each decide one bit, msb first
   assign sar_phase = in_conv && (tad_cnt_reg != 4'h0) &&
                      (tad_cnt_reg <= adc_seq_pkg::RESULT_BITS);
   assign bit_idx   = adc_seq_pkg::RESULT_BITS - tad_cnt_reg;
   assign trial_bit = sar_phase ? (10'h001 << bit_idx) : 10'h000;
   assign dac_next  = sar_reg | trial_bit;

   // reference pins leave the analog-input set when used as references
   assign mask_next = adc_seq_pkg::PIN_MAP[pcfg] &
                      ~(config_reg[adc_seq_pkg::REFSEL_BIT] ?
                        adc_seq_pkg::REF_PIN_MASK : 16'h0000);

   // left justify zeroes the six low bits of result_low
   assign res_high = justify_right ? {6'h00, result_reg[9:8]} :
                                     result_reg[9:2];
   assign res_low  = justify_right ? result_reg[7:0] :
                                     {result_reg[1:0], 6'h00};

   adc_tad_clock u_tad_clock (
      .i_clk     (i_clk),
      .i_rstn    (i_rstn),
      .i_enable  (power_on),
      .i_clk_sel (clk_sel),
      .i_sleep   (i_sleep),
      .i_rc_tick (i_rc_tick),
      .o_tick    (tad_tick)
   );

   // register read mux, unimplemented bits masked to zero
   always_comb begin
      case (i_addr)
         adc_seq_pkg::ADDR_CTRL_MAIN:
            rd_mux = (ctrl_reg & adc_seq_pkg::CTRL_MASK) |
                     ({7'h00, go_reg} << adc_seq_pkg::GO_BIT);
         adc_seq_pkg::ADDR_CONFIG_PINS:
            rd_mux = config_reg & adc_seq_pkg::CONFIG_MASK;
         adc_seq_pkg::ADDR_RESULT_HIGH: rd_mux = res_high;
         adc_seq_pkg::ADDR_RESULT_LOW:  rd_mux = res_low;
         adc_seq_pkg::ADDR_IRQ_STATUS:
            rd_mux = {6'h00, irq_en_reg, done_reg};
         default:                       rd_mux = 8'h00;
      endcase
   end

   // register and flag next values
   always_comb begin
      ctrl_next   = wr_ctrl ? (i_wdata & adc_seq_pkg::CTRL_MASK) : ctrl_reg;
      config_next = wr_config ? (i_wdata & adc_seq_pkg::CONFIG_MASK) :
                                config_reg;
      // go only sticks while the converter is powered
      if (complete) begin
         go_next = 1'b0;
      end else if (wr_ctrl) begin
         go_next = i_wdata[adc_seq_pkg::GO_BIT] &&
                   i_wdata[adc_seq_pkg::POWER_BIT];
      end else begin
         go_next = go_reg && power_on;
      end
      // completion wins over a software clear in the same cycle
      if (complete) begin
         done_next = 1'b1;
      end else if (wr_stat) begin
         done_next = i_wdata[adc_seq_pkg::DONE_BIT];
      end else begin
         done_next = done_reg;
      end
      irq_en_next = wr_stat ? i_wdata[adc_seq_pkg::IRQEN_BIT] : irq_en_reg;
      result_next = complete ? sar_reg : result_reg;
   end

   // sequencing
   always_comb begin
      state_next   = state_reg;
      tad_cnt_next = tad_tick ? tad_cnt_reg + 4'h1 : tad_cnt_reg;
      sar_next     = sar_reg;
      case (state_reg)
         adc_seq_pkg::ST_OFF: begin
            tad_cnt_next = 4'h0;
            if (power_on) begin
               state_next = adc_seq_pkg::ST_ACQ;
            end
         end
         adc_seq_pkg::ST_ACQ: begin
            tad_cnt_next = 4'h0;
            sar_next     = 10'h000;
            if (!power_on) begin
               state_next = adc_seq_pkg::ST_OFF;
            end else if (start) begin
               state_next = adc_seq_pkg::ST_CONV;
            end
         end
         adc_seq_pkg::ST_CONV: begin
            if (tad_tick && sar_phase) begin
               sar_next[bit_idx] = i_comparator;
            end
            if (!power_on) begin
               state_next = adc_seq_pkg::ST_OFF;
            end else if (abort || complete) begin
               state_next   = adc_seq_pkg::ST_WAIT;
               tad_cnt_next = 4'h0;
            end
         end
         adc_seq_pkg::ST_WAIT: begin
            if (!power_on) begin
               state_next = adc_seq_pkg::ST_OFF;
            end else if (holdoff_done) begin
               state_next = adc_seq_pkg::ST_ACQ;
            end
         end
         default: begin
            state_next   = adc_seq_pkg::ST_OFF;
            tad_cnt_next = 4'h0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg   <= adc_seq_pkg::ST_OFF;
         ctrl_reg    <= adc_seq_pkg::CTRL_RESET;
         config_reg  <= adc_seq_pkg::CONFIG_RESET;
         go_reg      <= 1'b0;
         done_reg    <= 1'b0;
         irq_en_reg  <= 1'b0;
         tad_cnt_reg <= 4'h0;
         sar_reg     <= 10'h000;
         result_reg  <= adc_seq_pkg::RESULT_RESET;
      end else begin
         state_reg   <= state_next;
         ctrl_reg    <= ctrl_next;
         config_reg  <= config_next;
         go_reg      <= go_next;
         done_reg    <= done_next;
         irq_en_reg  <= irq_en_next;
         tad_cnt_reg <= tad_cnt_next;
         sar_reg     <= sar_next;
         result_reg  <= result_next;
      end
   end

   // outputs registered from current register values and, for o_rdata and o_irq_request, port inputs, so they lag state_reg by one cycle
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata          <= 8'h00;
         o_channel        <= 4'h0;
         o_sample_connect <= 1'b0;
         o_dac_code       <= 10'h000;
         o_power_on       <= 1'b0;
         o_vref_ext       <= 1'b0;
         o_analog_mask    <= 16'h0000;
         o_done_flag      <= 1'b0;
         o_irq_request    <= 1'b0;
      end else begin
         o_rdata          <= i_rd ? rd_mux : 8'h00;
         o_channel        <= ctrl_reg[adc_seq_pkg::CHAN_MSB:
                                      adc_seq_pkg::CHAN_LSB];
         o_sample_connect <= in_acq && power_on;
         o_dac_code       <= dac_next;
         o_power_on       <= power_on;
         o_vref_ext       <= config_reg[adc_seq_pkg::REFSEL_BIT];
         o_analog_mask    <= mask_next;
         o_done_flag      <= done_reg;
         o_irq_request    <= done_reg && irq_en_reg && !i_global_irq_disable;
      end
   end

   default clocking dflt_cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence conv_end_s;
      in_conv && tad_tick && !abort &&
      (tad_cnt_reg == adc_seq_pkg::CONV_TADS - 4'h1);
   endsequence

   sequence wait_exit_s;
      in_wait && tad_tick && power_on &&
      (tad_cnt_reg == adc_seq_pkg::HOLDOFF_TADS - 4'h1);
   endsequence

   complete_load_a: assert property (conv_end_s |=>
      done_reg && !go_reg && (result_reg == $past(sar_reg)))
      else $error("completion did not load result and flags");

   go_held_a: assert property (
      in_conv && !complete && !abort && power_on |=> go_reg)
      else $error("go dropped before twelve periods");

   holdoff_gap_a: assert property (complete |=> in_wait &&
      !o_sample_connect ##1 !o_sample_connect)
      else $error("acquisition resumed without holdoff");

   restart_acq_a: assert property (wait_exit_s |=> in_acq
      ##1 o_sample_connect)
      else $error("acquisition did not restart after holdoff");

   abort_keep_a: assert property (abort && power_on |=> in_wait &&
      $stable(result_reg) && !go_reg)
      else $error("abort changed result or state");

   power_off_a: assert property (!power_on |=>
      (state_reg == adc_seq_pkg::ST_OFF) ##1 !o_sample_connect)
      else $error("converter active while powered down");

   channel_out_a: assert property (wr_ctrl ##1 1'b1 |=>
      o_channel == $past(i_wdata[7:4], 2))
      else $error("channel output mismatch");

   left_zero_a: assert property (
      i_rd && (i_addr == adc_seq_pkg::ADDR_RESULT_LOW) && !justify_right
      |=> o_rdata[5:0] == 6'h00)
      else $error("left justified low bits not zero");

   ctrl_unimpl_a: assert property (
      i_rd && (i_addr == adc_seq_pkg::ADDR_CTRL_MAIN)
      |=> !o_rdata[3] && !o_rdata[1])
      else $error("unimplemented control bits read nonzero");

   sleep_clock_a: assert property (
      i_sleep && (clk_sel != adc_seq_pkg::CLK_RC) ##1 i_sleep |-> !tad_tick)
      else $error("conversion clock ran in sleep off rc");

endmodule

//--- analog_front_model.sv
// behavioural analog side: channel levels, holding capacitor, comparator
`timescale 1ns/1ps
module analog_front_model (
   // converter side
   input  wire logic [3:0]   i_channel,
   input  wire logic         i_sample_connect,
   input  wire logic [9:0]   i_dac_code,
   input  wire logic         i_power_on,
   // levels set by the bench, ten bits per channel, channel 0 lowest
   input  wire logic [159:0] i_levels,
   // decision
   output logic              o_comparator
);
   logic [9:0] held = 10'h000;

   // capacitor follows the channel only while connected
   always @* begin
      if (i_sample_connect) begin
         held = i_levels[i_channel*10 +: 10];
      end
   end
   // unpowered comparator decides nothing useful
   assign o_comparator = i_power_on & (held >= i_dac_code);
endmodule

//--- adc_sequencer_control_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
   mismatches++; $display("wrong value %s expected %h seen %h", \
   what, exp, got); end end
module adc_sequencer_control_tb;
   logic        i_clk, i_rstn, i_wr, i_rd, i_sleep;
   logic        i_rc_tick = 1'b0;
   logic        i_global_irq_disable, comparator;
   logic [7:0]  i_addr, i_wdata, o_rdata, rd;
   logic [3:0]  o_channel;
   logic        o_sample_connect, o_power_on, o_vref_ext;
   logic        o_done_flag, o_irq_request;
   logic [9:0]  o_dac_code, last;
   logic [15:0] o_analog_mask;
   logic [15:0][9:0] levels;
   logic [2:0]  rc_cnt = 3'h0;
   int          mismatches, compares, cyc, p;
   logic [15:0] pin_exp [8] = '{16'hFFFF, 16'h7F7F, 16'h3F3F, 16'h1F1F,
                                16'h0F0F, 16'h0707, 16'h0303, 16'h0000};
   logic [9:0]  lvl_tab [4] = '{10'h3FF, 10'h001, 10'h2A5, 10'h15A};

   adc_sequencer_control adc_sequencer_control_i (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
      .i_rc_tick(i_rc_tick), .i_global_irq_disable(i_global_irq_disable),
      .i_comparator(comparator), .o_channel(o_channel),
      .o_sample_connect(o_sample_connect), .o_dac_code(o_dac_code),
      .o_power_on(o_power_on), .o_vref_ext(o_vref_ext),
      .o_analog_mask(o_analog_mask), .o_done_flag(o_done_flag),
      .o_irq_request(o_irq_request));

   analog_front_model analog_front_model_i (
      .i_channel(o_channel), .i_sample_connect(o_sample_connect),
      .i_dac_code(o_dac_code), .i_power_on(o_power_on),
      .i_levels(levels), .o_comparator(comparator));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // rc oscillator stand-in, one tick every five clocks
   always @(posedge i_clk) begin
      rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
      i_rc_tick <= (rc_cnt == 3'h4);
   end

   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rd = o_rdata;
      `CHECK("register read", e, rd)
   endtask
   // waits are bounded so a dead sequencer shows up as a count
   task automatic wait_connect;
      cyc = 0;
      while (o_sample_connect !== 1'b1 && cyc < 2000) begin
         @(posedge i_clk);
         #1 cyc++;
      end
   endtask
   task automatic wait_done;
      cyc = 0;
      while (o_done_flag !== 1'b1 && cyc < 2000) begin
         @(posedge i_clk);
         #1 cyc++;
      end
   endtask
   task automatic convert(input logic [1:0] sel, input logic [9:0] lvl);
      p = (sel == 2'h3) ? 5 : (sel == 2'h0) ? 8 : (sel == 2'h1) ? 32 : 64;
      levels[3] = lvl;
      last = lvl;
      wr(8'h15, {sel, 6'h20});
      wr(8'h14, 8'h31);
      wr(8'h18, 8'h00);
      wait_connect();
      `CHECK("analog pin", 1'b1, o_analog_mask[3])
      repeat (8) @(posedge i_clk);
      wr(8'h14, 8'h35);
      wait_done();
      `CHECK("conversion time", 1'b1, cyc >= 11*p+3 && cyc <= 12*p+2)
      `CHECK("capacitor", 1'b0, o_sample_connect)
      wait_connect();
      `CHECK("holdoff", 1'b1, cyc >= 2*p-1 && cyc <= 2*p+2)
      chk(8'h14, 8'h31);
      chk(8'h16, {6'h00, lvl[9:8]});
      chk(8'h17, lvl[7:0]);
      chk(8'h18, 8'h01);
   endtask

   initial begin
      repeat (30000) @(posedge i_clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      {i_rstn, i_wr, i_rd, i_sleep, i_global_irq_disable} = 5'h00;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      mismatches = 0;
      compares = 0;
      for (int i = 0; i < 16; i++) levels[i] = 10'h000;
      repeat (4) @(posedge i_clk);
      i_rstn <= 1'b1;
      for (int a = 20; a <= 24; a++) chk(a[7:0], 8'h00);
      chk(8'h20, 8'h00);
      wr(8'h14, 8'hFA);
      chk(8'h14, 8'hF0);
      `CHECK("channel", 4'hF, o_channel)
      `CHECK("power", 1'b0, o_power_on)
      wr(8'h15, 8'hFF);
      chk(8'h15, 8'hEF);
      wr(8'h20, 8'hFF);
      chk(8'h20, 8'h00);
      for (int c = 0; c < 8; c++) begin
         for (int r = 0; r < 2; r++) begin
            wr(8'h15, {4'h0, c[2:0], r[0]});
            repeat (2) @(posedge i_clk);
            #1;
            `CHECK("analog mask", pin_exp[c] & (r ? 16'hFFFC : 16'hFFFF),
                   o_analog_mask)
            `CHECK("ref select", r[0], o_vref_ext)
         end
      end
      for (int s = 0; s < 4; s++) convert(s[1:0], lvl_tab[s]);
      wr(8'h15, 8'h40);
      chk(8'h16, last[9:2]);
      chk(8'h17, {last[1:0], 6'h00});
      wr(8'h18, 8'h00);
      levels[3] = 10'h0F0;
      wr(8'h14, 8'h35);
      repeat (100) @(posedge i_clk);
      wr(8'h14, 8'h31);
      chk(8'h14, 8'h31);
      chk(8'h18, 8'h00);
      chk(8'h16, last[9:2]);
      wait_connect();
      `CHECK("abort restart", 1'b1, cyc >= 28 && cyc <= 60)
      i_sleep <= 1'b1;
      wr(8'h15, 8'h20);
      wr(8'h14, 8'h35);
      repeat (300) @(posedge i_clk);
      #1;
      `CHECK("sleep stall", 1'b0, o_done_flag)
      chk(8'h14, 8'h35);
      convert(2'h3, 10'h2C3);
      i_sleep <= 1'b0;
      wr(8'h18, 8'h03);
      repeat (2) @(posedge i_clk);
      #1;
      `CHECK("irq request", 1'b1, o_irq_request)
      i_global_irq_disable <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      `CHECK("irq masked", 1'b0, o_irq_request)
      i_global_irq_disable <= 1'b0;
      wr(8'h18, 8'h00);
      repeat (2) @(posedge i_clk);
      #1;
      `CHECK("irq cleared", 1'b0, o_irq_request)
      wr(8'h14, 8'h00);
      repeat (2) @(posedge i_clk);
      #1;
      `CHECK("power off", 1'b0, o_power_on)
      `CHECK("off capacitor", 1'b0, o_sample_connect)
      report_and_stop();
   end
endmodule
